// File: design/sbl_pkg.sv
// Purpose: Shared constants for the screen block layout logic
// Assumes: 8-bit registers, one per aligned 32-bit Avalon word
// Notes: Byte address of a register is four times its index
`default_nettype none
package sbl_pkg;
    // ========================================
    // Register indices
    localparam int IDX_W = 6;
    localparam logic [IDX_W-1:0] IDX_PANEL = 6'h00;
    localparam logic [IDX_W-1:0] IDX_FRAME_LINES = 6'h05;
    localparam logic [IDX_W-1:0] IDX_PITCH = 6'h06;
    localparam logic [IDX_W-1:0] IDX_B1_LINES = 6'h0D;
    localparam logic [IDX_W-1:0] IDX_B2_LINES = 6'h10;
    localparam logic [IDX_W-1:0] IDX_STATUS = 6'h20;
    localparam int NUM_BLOCKS = 4;
    localparam logic [IDX_W-1:0] START_LO_IDX [NUM_BLOCKS] = '{6'h0B, 6'h0E, 6'h11, 6'h13};
    localparam logic [IDX_W-1:0] START_HI_IDX [NUM_BLOCKS] = '{6'h0C, 6'h0F, 6'h12, 6'h14};
    // ========================================
    // Field layout and reset values
    localparam int ADDR_LSB = 2;
    localparam int PANEL_DUAL_BIT = 3;
    localparam int BE_LANE0 = 0;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [15:0] START_RST = 16'h0000;
    localparam logic [7:0] ONE_LINE = 8'h01;
endpackage
`default_nettype wire

// File: design/sbl_start_if.sv
// Purpose: Carrier between the register decoder and one start address store
// Assumes: Single clock domain
// Notes: Decoder drives strobes, store returns staged low byte and live address
`default_nettype none
interface sbl_start_if;
    logic wr_low;
    logic wr_high;
    logic [7:0] wdata;
    logic [7:0] low_staged;
    logic [15:0] value;
    modport ctrl (output wr_low, output wr_high, output wdata, input low_staged, input value);
    modport store (input wr_low, input wr_high, input wdata, output low_staged, output value);
endinterface
`default_nettype wire

// File: design/sbl_start_reg.sv
// Purpose: One 16-bit screen block start address with low byte staging
// Assumes: Low byte written before high byte
// Notes: Live address changes only on a high byte write
`default_nettype none
module sbl_start_reg (
    input wire logic clk_sys,
    input wire logic sys_rst,
    sbl_start_if.store port
);
    logic [7:0] low_ff;
    logic [15:0] value_ff;

    // ========================================
    // Staging and commit
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            low_ff <= sbl_pkg::REG_RST;
        end else if (port.wr_low) begin
            low_ff <= port.wdata;
        end
    end

    // Old address stays in use so refresh never sees a torn value
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            value_ff <= sbl_pkg::START_RST;
        end else if (port.wr_high) begin
            value_ff <= {port.wdata, low_ff};
        end
    end

    assign port.low_staged = low_ff;
    assign port.value = value_ff;

    AST_HIGH_COMMIT: assert property (@(posedge clk_sys) disable iff (sys_rst)
        port.wr_high |=> value_ff == {$past(port.wdata), $past(low_ff)})
        else $error("start address not committed on high byte write");
    AST_LOW_HOLD: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (port.wr_low && !port.wr_high) |=> $stable(value_ff))
        else $error("start address moved on low byte write");
endmodule
`default_nettype wire

// File: design/sbl_layout.sv
// Purpose: Screen block layout registers and per-line refresh address generation
// Assumes: Avalon-MM slave with waitrequest; frame_start and line_adv come from refresh timing
// Notes: Single clock; pointers advance by the pitch register each line, except where layer 1 or 2 reloads at a block split
//
// The Avalon-MM interface to the registers was decided locally.
`default_nettype none
module sbl_layout (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic frame_start,
    input wire logic line_adv,
    output logic [15:0] layer1_addr,
    output logic [15:0] layer2_addr,
    output logic [15:0] layer3_addr,
    output logic layer1_blank,
    output logic layer2_blank,
    output logic [7:0] block3_lines,
    output logic [7:0] block4_lines,
    output logic dual_panel
);
    logic [sbl_pkg::IDX_W-1:0] idx;
    logic wr_en;
    logic rd_ack_ff;
    logic [31:0] readdata_ff;
    logic [7:0] rd_mux;
    logic [7:0] panel_ff;
    logic [7:0] frame_lines_ff;
    logic [7:0] pitch_ff;
    logic [7:0] block1_lines_ff;
    logic [7:0] block2_lines_ff;
    logic [15:0] sad [sbl_pkg::NUM_BLOCKS];
    logic [7:0] sad_low [sbl_pkg::NUM_BLOCKS];
    logic [7:0] line_ff;
    logic [7:0] nxt_line;
    logic [8:0] half_sum;
    logic [7:0] half_m1;
    logic [7:0] min_size;
    logic [7:0] nxt_row;
    logic nxt_lower;
    logic [15:0] l1_ff;
    logic [15:0] l2_ff;
    logic [15:0] l3_ff;
    logic blank1_ff;
    logic blank2_ff;
    logic [7:0] b3_lines_ff;
    logic [7:0] b4_lines_ff;

    sbl_start_if st_if [sbl_pkg::NUM_BLOCKS] ();

    // ========================================
    // Avalon decode
    assign idx = avs_address[sbl_pkg::ADDR_LSB +: sbl_pkg::IDX_W];
    assign wr_en = avs_write && avs_byteenable[sbl_pkg::BE_LANE0];
    // Reads take one wait cycle so read data come from a register
    assign avs_waitrequest = avs_read && !rd_ack_ff;
    assign avs_readdata = readdata_ff;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rd_ack_ff <= 1'b0;
        end else begin
            rd_ack_ff <= avs_read && !rd_ack_ff;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            readdata_ff <= 32'h0000_0000;
        end else if (avs_read && !rd_ack_ff) begin
            readdata_ff <= {24'h00_0000, rd_mux};
        end
    end

    // ========================================
    // Start address stores, blocks 1 to 4
    genvar g;
    generate
        for (g = 0; g < sbl_pkg::NUM_BLOCKS; g++) begin : g_start
            assign st_if[g].wr_low = wr_en && (idx == sbl_pkg::START_LO_IDX[g]);
            assign st_if[g].wr_high = wr_en && (idx == sbl_pkg::START_HI_IDX[g]);
            assign st_if[g].wdata = avs_writedata[7:0];
            assign sad[g] = st_if[g].value;
            assign sad_low[g] = st_if[g].low_staged;
            sbl_start_reg u_start (
                .clk_sys(clk_sys),
                .sys_rst(sys_rst),
                .port(st_if[g])
            );
        end
    endgenerate

    // ========================================
    // Configuration registers
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            panel_ff <= sbl_pkg::REG_RST;
            frame_lines_ff <= sbl_pkg::REG_RST;
            pitch_ff <= sbl_pkg::REG_RST;
            block1_lines_ff <= sbl_pkg::REG_RST;
            block2_lines_ff <= sbl_pkg::REG_RST;
        end else if (wr_en) begin
            case (idx)
                sbl_pkg::IDX_PANEL: panel_ff <= avs_writedata[7:0];
                sbl_pkg::IDX_FRAME_LINES: frame_lines_ff <= avs_writedata[7:0];
                sbl_pkg::IDX_PITCH: pitch_ff <= avs_writedata[7:0];
                sbl_pkg::IDX_B1_LINES: block1_lines_ff <= avs_writedata[7:0];
                sbl_pkg::IDX_B2_LINES: block2_lines_ff <= avs_writedata[7:0];
                default: ;
            endcase
        end
    end

    assign dual_panel = panel_ff[sbl_pkg::PANEL_DUAL_BIT];

    // Unmapped indices read as zero
    always_comb begin
        rd_mux = 8'h00;
        for (int i = 0; i < sbl_pkg::NUM_BLOCKS; i++) begin
            if (idx == sbl_pkg::START_LO_IDX[i]) begin
                rd_mux = sad_low[i];
            end
            if (idx == sbl_pkg::START_HI_IDX[i]) begin
                rd_mux = sad[i][15:8];
            end
        end
        case (idx)
            sbl_pkg::IDX_PANEL: rd_mux = panel_ff;
            sbl_pkg::IDX_FRAME_LINES: rd_mux = frame_lines_ff;
            sbl_pkg::IDX_PITCH: rd_mux = pitch_ff;
            sbl_pkg::IDX_B1_LINES: rd_mux = block1_lines_ff;
            sbl_pkg::IDX_B2_LINES: rd_mux = block2_lines_ff;
            sbl_pkg::IDX_STATUS: rd_mux = line_ff;
            default: ;
        endcase
    end

    // ========================================
    // Derived block sizes
    assign half_sum = ({1'b0, frame_lines_ff} + {1'b0, sbl_pkg::ONE_LINE}) >> 1;
    assign half_m1 = half_sum[7:0] - sbl_pkg::ONE_LINE;
    assign min_size = (block1_lines_ff < block2_lines_ff) ? block1_lines_ff : block2_lines_ff;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            b3_lines_ff <= sbl_pkg::REG_RST;
            b4_lines_ff <= sbl_pkg::REG_RST;
        end else begin
            b3_lines_ff <= dual_panel ? half_m1 : min_size;
            b4_lines_ff <= half_m1;
        end
    end

    assign block3_lines = b3_lines_ff;
    assign block4_lines = b4_lines_ff;

    // ========================================
    // Line counter and row within panel half
    assign nxt_line = frame_start ? 8'h00 : line_ff + sbl_pkg::ONE_LINE;
    assign nxt_lower = dual_panel && (nxt_line > half_m1);
    assign nxt_row = nxt_lower ? nxt_line - half_sum[7:0] : nxt_line;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            line_ff <= 8'h00;
        end else if (frame_start || line_adv) begin
            line_ff <= nxt_line;
        end
    end

    // ========================================
    // Refresh address pointers
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            l1_ff <= sbl_pkg::START_RST;
            l2_ff <= sbl_pkg::START_RST;
            l3_ff <= sbl_pkg::START_RST;
        end else if (frame_start) begin
            l1_ff <= sad[0];
            l2_ff <= sad[1];
            l3_ff <= sad[2];
        end else if (line_adv) begin
            l3_ff <= l3_ff + {8'h00, pitch_ff};
            if (dual_panel && line_ff == half_m1) begin
                l1_ff <= sad[2];
                l2_ff <= sad[3];
            end else if (!dual_panel && line_ff == block1_lines_ff) begin
                l1_ff <= sad[2];
                l2_ff <= l2_ff + {8'h00, pitch_ff};
            end else begin
                l1_ff <= l1_ff + {8'h00, pitch_ff};
                l2_ff <= l2_ff + {8'h00, pitch_ff};
            end
        end
    end

    assign layer1_addr = l1_ff;
    assign layer2_addr = l2_ff;
    assign layer3_addr = l3_ff;

    // ========================================
    // Blanking: rows past a block's size inside a panel half show nothing; layer 1 blanks only in dual panel
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            blank1_ff <= 1'b0;
            blank2_ff <= 1'b0;
        end else if (frame_start || line_adv) begin
            blank1_ff <= dual_panel && (nxt_row > block1_lines_ff);
            blank2_ff <= nxt_row > block2_lines_ff;
        end
    end

    assign layer1_blank = blank1_ff;
    assign layer2_blank = blank2_ff;

    // ========================================
    // Checks
    sequence s_read_taken(logic [sbl_pkg::IDX_W-1:0] ri);
        avs_read && !avs_waitrequest && idx == ri;
    endsequence

    sequence s_dual_half_end;
        dual_panel && line_adv && !frame_start && line_ff == half_m1;
    endsequence

    AST_RESET_ZERO: assert property (@(posedge clk_sys)
        $fell(sys_rst) |-> (block2_lines_ff == 8'h00 && sad[1] == 16'h0000
        && sad[2] == 16'h0000 && sad[3] == 16'h0000))
        else $error("registers not zero after reset");
    AST_READ_SIZE: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_read_taken(sbl_pkg::IDX_B2_LINES) |-> avs_readdata[7:0] == block2_lines_ff)
        else $error("block 2 size readback wrong");
    AST_READ_WAIT: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (avs_read && !rd_ack_ff) |-> avs_waitrequest ##1 (!avs_waitrequest || !avs_read))
        else $error("read answer not one cycle late");
    // Derived sizes lag their sources by one stage; reset edge excluded
    AST_B3_MIN: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (!sys_rst && !dual_panel && $stable(block1_lines_ff) && $stable(block2_lines_ff)
        && $stable(dual_panel)) |=> block3_lines == $past(min_size))
        else $error("block 3 lines not the smaller size");
    AST_B4_HALF: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (!sys_rst && $stable(frame_lines_ff)) |=> block4_lines == $past(half_m1))
        else $error("block 4 lines not derived from frame lines");
    AST_DUAL_LOWER: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_dual_half_end |=> (layer1_addr == $past(sad[2]) && layer2_addr == $past(sad[3])))
        else $error("lower half not fetched from blocks 3 and 4");
    AST_SINGLE_SPLIT: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (!dual_panel && line_adv && !frame_start && line_ff == block1_lines_ff)
        |=> layer1_addr == $past(sad[2]))
        else $error("layer 1 did not move to block 3");
    AST_FRAME_LOAD: assert property (@(posedge clk_sys) disable iff (sys_rst)
        frame_start |=> (layer1_addr == $past(sad[0]) && layer2_addr == $past(sad[1])
        && line_ff == 8'h00))
        else $error("frame did not restart at block start addresses");
    AST_ADVANCE: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (line_adv && !frame_start) |=> layer3_addr == $past(l3_ff) + {8'h00, $past(pitch_ff)})
        else $error("pointer did not advance by pitch");
    AST_DUAL_BLANK: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (dual_panel && line_adv && !frame_start && nxt_row > block1_lines_ff)
        |=> layer1_blank)
        else $error("line beyond block 1 not blanked");

    sequence s_line_step;
        line_adv && !frame_start;
    endsequence

    sequence s_single_step;
        !dual_panel && (frame_start || line_adv);
    endsequence

    sequence s_dual_step;
        dual_panel && (frame_start || line_adv);
    endsequence

    // Writes never stall, so a master needs no retry path
    AST_WRITE_NO_WAIT: assert property (@(posedge clk_sys) disable iff (sys_rst)
        avs_write |-> !avs_waitrequest)
        else $error("write stalled");
    AST_B3_DUAL: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (!sys_rst && dual_panel) |=> block3_lines == $past(half_m1))
        else $error("dual block 3 lines not derived from frame lines");
    AST_LINE_STEP: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_line_step |=> line_ff == $past(line_ff) + sbl_pkg::ONE_LINE)
        else $error("line counter did not step");
    AST_SINGLE_KEEP1: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_single_step |=> !layer1_blank)
        else $error("layer 1 blanked in single panel");
    AST_SINGLE_BLANK2: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_single_step ##0 (nxt_row > block2_lines_ff) |=> layer2_blank)
        else $error("line beyond block 2 not blanked");
    AST_DUAL_KEEP: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_dual_step ##0 (nxt_row <= block1_lines_ff) |=> !layer1_blank)
        else $error("line inside block 1 blanked");
endmodule
`default_nettype wire

// File: testbench/sbl_refresh_model.sv
// Purpose: Refresh timing stand-in issuing frame and line pulses
// Assumes: Same clock as the layout block
// Notes: Line pulses before the first frame are dropped
`default_nettype none
module sbl_refresh_model (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic frame_req,
    input wire logic line_req,
    output logic frame_start,
    output logic line_adv
);
    timeunit 1ns;
    timeprecision 1ps;
    logic framed_ff;
    // ========================================
    // Pulse generation
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            framed_ff <= 1'b0;
            frame_start <= 1'b0;
            line_adv <= 1'b0;
        end else begin
            framed_ff <= framed_ff | frame_req;
            frame_start <= frame_req;
            // Keeps frame before line order
            line_adv <= line_req & framed_ff & ~frame_req;
        end
    end
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
// Purpose: Self-checking bench for the screen block layout block
// Assumes: Register index times four is the byte address
// Notes: Expected fetch addresses are rebuilt from programmed values
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, sys_rst, avs_read, avs_write, avs_waitrequest;
    logic frame_start, line_adv, frame_req, line_req;
    logic layer1_blank, layer2_blank, dual_panel;
    logic [7:0] avs_address, block3_lines, block4_lines;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [3:0] avs_byteenable;
    logic [15:0] layer1_addr, layer2_addr, layer3_addr, e1, e2;
    logic [15:0] st [4] = '{16'h0110, 16'h2020, 16'h4030, 16'h6040};
    int err_count, total_checks, row;
    sbl_layout u_sbl_layout (.clk_sys, .sys_rst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .frame_start,
        .line_adv, .layer1_addr, .layer2_addr, .layer3_addr, .layer1_blank, .layer2_blank,
        .block3_lines, .block4_lines, .dual_panel);
    sbl_refresh_model u_sbl_refresh_model (.clk_sys, .sys_rst, .frame_req, .line_req,
        .frame_start, .line_adv);
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // ========================================
    // Tasks
    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] d,
                       input logic [3:0] be);
        int n;
        n = 0;
        @(posedge clk_sys);
        avs_write <= wr;
        avs_read <= ~wr;
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h000000, d};
        avs_byteenable <= be;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 20) begin
            err_count++;
            print_verdict();
        end
    endtask
    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d, 4'h1);
    endtask
    task automatic rdc(input logic [5:0] idx, input logic [7:0] exp, input string what);
        bus(1'b0, idx, 8'h00, 4'h1);
        check(rd[15:0], {8'h00, exp}, what);
        check(rd[31:16], 16'h0000, what);
    endtask
    // Pulse lands two edges later; sample on the falling edge
    task automatic pulse(input logic frame);
        @(posedge clk_sys);
        frame_req <= frame;
        line_req <= ~frame;
        @(posedge clk_sys);
        frame_req <= 1'b0;
        line_req <= 1'b0;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    task automatic line_chk(input logic [15:0] a1, input logic [15:0] a2, input logic b1,
                            input logic b2);
        check(layer1_addr, a1, "layer1 address");
        check(layer2_addr, a2, "layer2 address");
        check({15'h0000, layer1_blank}, {15'h0000, b1}, "layer1 blank");
        check({15'h0000, layer2_blank}, {15'h0000, b2}, "layer2 blank");
    endtask
    // ========================================
    // Main sequence
    initial begin
        sys_rst = 1'b1;
        {avs_read, avs_write, frame_req, line_req} = 4'h0;
        avs_address = 8'h00;
        avs_writedata = 32'h00000000;
        avs_byteenable = 4'h0;
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        for (int k = 1; k < 4; k++) begin
            rdc(sbl_pkg::START_LO_IDX[k], 8'h00, "start low reset");
            rdc(sbl_pkg::START_HI_IDX[k], 8'h00, "start high reset");
        end
        rdc(sbl_pkg::IDX_B2_LINES, 8'h00, "block2 size reset");
        wr(6'h3F, 8'hA5);
        rdc(6'h3F, 8'h00, "unmapped read");
        bus(1'b1, sbl_pkg::IDX_B2_LINES, 8'h77, 4'hE);
        rdc(sbl_pkg::IDX_B2_LINES, 8'h00, "lane masked write");
        // Low bytes alone leave the live addresses untouched
        for (int k = 0; k < 4; k++) wr(sbl_pkg::START_LO_IDX[k], st[k][7:0]);
        for (int k = 1; k < 4; k++) rdc(sbl_pkg::START_LO_IDX[k], st[k][7:0], "low");
        pulse(1'b1);
        line_chk(16'h0000, 16'h0000, 1'b0, 1'b0);
        check(layer3_addr, 16'h0000, "layer3 staged");
        for (int k = 0; k < 4; k++) wr(sbl_pkg::START_HI_IDX[k], st[k][15:8]);
        for (int k = 1; k < 4; k++) rdc(sbl_pkg::START_HI_IDX[k], st[k][15:8], "high");
        // Single panel, two layers, block 3 below block 1
        wr(sbl_pkg::IDX_PITCH, 8'h10);
        wr(sbl_pkg::IDX_FRAME_LINES, 8'h09);
        wr(sbl_pkg::IDX_B1_LINES, 8'h05);
        wr(sbl_pkg::IDX_B2_LINES, 8'h03);
        rdc(sbl_pkg::IDX_B2_LINES, 8'h03, "block2 size");
        pulse(1'b1);
        line_chk(st[0], st[1], 1'b0, 1'b0);
        check(layer3_addr, st[2], "layer3 start");
        check({8'h00, block3_lines}, 16'h0003, "block3 lines");
        check({8'h00, block4_lines}, 16'h0004, "block4 lines");
        check({15'h0000, dual_panel}, 16'h0000, "single panel");
        for (int i = 1; i <= 8; i++) begin
            pulse(1'b0);
            e1 = (i <= 5) ? 16'(st[0] + 16 * i) : 16'(st[2] + 16 * (i - 6));
            line_chk(e1, 16'(st[1] + 16 * i), 1'b0, i > 3);
        end
        // Dual panel, block 1 two lines short of half
        wr(sbl_pkg::IDX_PANEL, 8'h08);
        wr(sbl_pkg::IDX_B1_LINES, 8'h02);
        wr(sbl_pkg::IDX_B2_LINES, 8'h04);
        pulse(1'b1);
        check({15'h0000, dual_panel}, 16'h0001, "dual panel");
        check({8'h00, block3_lines}, 16'h0004, "dual block3 lines");
        check({8'h00, block4_lines}, 16'h0004, "dual block4 lines");
        for (int i = 1; i <= 9; i++) begin
            pulse(1'b0);
            row = (i < 5) ? i : i - 5;
            e1 = (i < 5) ? 16'(st[0] + 16 * i) : 16'(st[2] + 16 * row);
            e2 = (i < 5) ? 16'(st[1] + 16 * i) : 16'(st[3] + 16 * row);
            line_chk(e1, e2, row > 2, row > 4);
        end
        rdc(sbl_pkg::IDX_STATUS, 8'h09, "current line");
        // Unpartitioned single panel, three full-height layers
        wr(sbl_pkg::IDX_PANEL, 8'h00);
        wr(sbl_pkg::IDX_B1_LINES, 8'h0A);
        wr(sbl_pkg::IDX_B2_LINES, 8'h0A);
        pulse(1'b1);
        check({8'h00, block3_lines}, 16'h000A, "full block3 lines");
        for (int i = 1; i <= 9; i++) begin
            pulse(1'b0);
            line_chk(16'(st[0] + 16 * i), 16'(st[1] + 16 * i), 1'b0, 1'b0);
            check(layer3_addr, 16'(st[2] + 16 * i), "layer3 address");
        end
        print_verdict();
    end
endmodule
`default_nettype wire
